/* rtl/lcs_map.svh */
`ifndef LCS_MAP_SVH
`define LCS_MAP_SVH
// timing
`define LCS_CLK_MHZ 25
`define LCS_STEP_US 400
`define LCS_SEC_US 1000000
`define LCS_DET_SEC 16'h0003
`define LCS_OPEN_SEC 16'h0002
`define LCS_BSR_HOLD 4'h8
// thresholds
`define LCS_PRE_ENTER 16'h39e6
`define LCS_PRE_EXIT 16'h3aea
`define LCS_SNS_2V4 16'h0960
`define LCS_SNS_2V6 16'h0a28
`define LCS_VREG_MAX 5'h1f
// register byte offsets
`define LCS_A_CTRL 8'h00
`define LCS_A_ICHG 8'h04
`define LCS_A_VCHG 8'h08
`define LCS_A_ABS 8'h0c
`define LCS_A_MAXCHG 8'h10
`define LCS_A_MAXCV 8'h14
`define LCS_A_MAXABS 8'h18
`define LCS_A_CX 8'h1c
`define LCS_A_STAT 8'h20
`define LCS_A_BSR 8'h24
`define LCS_A_IBSR 8'h28
`define LCS_A_TMR 8'h2c
// control and status fields
`define LCS_C_SUSP 0
`define LCS_C_RUNBSR 1
`define LCS_C_LFP 2
`define LCS_C_IRQEN 3
`define LCS_C_CXEN 4
`define LCS_S_FAULT 11
// reset values
`define LCS_R_MAXCHG 16'hfd20
`define LCS_R_MAXCV 16'h0e10
`define LCS_R_MAXABS 16'h0384
`define LCS_R_ICHG 5'h1f
`define LCS_R_VCHG 5'h1f
`endif

/* rtl/lcs_pkg.sv */
package lcs_pkg;
  typedef enum logic [3:0] {
    ST_SUSP, ST_DET, ST_OPEN, ST_FAULT, ST_SOFT, ST_PRE, ST_ABS,
    ST_CCCV, ST_BSR_A, ST_BSR_D, ST_DONE, ST_TMO
  } lcs_state_t;

  typedef struct packed {
    lcs_state_t st;
    lcs_state_t ret;
    logic [15:0] sec;
    logic [15:0] tmr;
    logic [4:0] dac;
    logic [4:0] vreg;
    logic peak;
    logic iin;
    logic uvcl;
    logic fault;
    logic irq;
    logic chg_en;
    logic load_en;
    logic susp;
    logic pend;
    logic lfp;
    logic irq_en;
    logic cx_en;
    logic [4:0] ichg;
    logic [4:0] vchg;
    logic [4:0] aoff;
    logic [15:0] max_chg;
    logic [15:0] max_cv;
    logic [15:0] max_abs;
    logic [15:0] cx_thr;
    logic [3:0] hold;
    logic [15:0] v1;
    logic [15:0] i1;
    logic [15:0] dv;
    logic [15:0] di;
    logic [16:0] rem;
    logic [4:0] nbit;
    logic [15:0] bsr;
    logic [15:0] ibsr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } lcs_state_vec_t;
endpackage

/* rtl/lcs_sequencer.sv */
// Behaviour
// - presence check with small load, stable goes soft-start
// - unstable: brief min-current test, else fault
// - open thermistor declares detection fault
// - detection fault raises enabled interrupt
// - soft-start ramps current one step per 400us
// - safety timer starts at soft-start, timeout stops
// - timeout exits below 35 percent, restarts
// - safety timer clears at done and at timeout exit
// - input near battery, suspend, fault suspend
// - li-ion deep discharge precharges at tenth
// - precharge ends above 15082, enters cc-cv
// - below 2.4V peak current mode, hysteresis
// - iron-phosphate has no precharge phase
// - iron-phosphate nonzero absorb offset starts absorb phase
// - absorb target is sum, clamped at maximum
// - input limits reduce current, flags reported
// - absorb ends on time or low current
// - leaving absorb lowers regulation voltage
// - iron-phosphate cv-timer, low-current or none
// - current servo target never above 32mV
// - resistance request suspends, divides, stores
// - queued request runs after next soft-start
`timescale 1ns/1ps
`include "lcs_map.svh"
module lcs_sequencer #(
  parameter int unsigned STEP_CYC = `LCS_STEP_US * `LCS_CLK_MHZ,
  parameter int unsigned SEC_STEPS = `LCS_SEC_US / `LCS_STEP_US
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] filtered_battery_code,
  input wire logic [15:0] battery_sense_input,
  input wire logic [15:0] battery_current_reading,
  input wire logic vin_near_batt,
  input wire logic sys_fault,
  input wire logic thermistor_input,
  input wire logic batt_stable,
  input wire logic batt_in_range,
  input wire logic batt_below_35pct,
  input wire logic cv_reached,
  input wire logic iin_limit_hit,
  input wire logic undervoltage_feedback_input,
  output logic charger_en,
  output logic detect_load_en,
  output logic [4:0] icharge_dac,
  output logic [4:0] vreg_code,
  output logic peak_mode,
  output logic detect_irq
);
  import lcs_pkg::*;

  lcs_state_vec_t q;
  lcs_state_vec_t n;
  logic step_tick;
  logic sec_tick;

  // ==========================================================
  // time base
  lcs_tick #(.DIV(STEP_CYC)) u_step (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .en(1'b1),
    .tick(step_tick)
  );

  // seconds derived from the step tick keeps both in phase
  lcs_tick #(.DIV(SEC_STEPS)) u_sec (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .en(step_tick),
    .tick(sec_tick)
  );

  // ==========================================================
  // helpers
  function automatic logic [4:0] div10(input logic [4:0] v);
    // nine bits hold 31 * 13 without wrapping
    div10 = 5'((9'(v) * 9'h00d) >> 7);
  endfunction

  function automatic logic [15:0] sub_sat(input logic [15:0] a,
                                          input logic [15:0] b);
    sub_sat = (a > b) ? a - b : 16'h0;
  endfunction

  function automatic logic [15:0] inc_sat(input logic [15:0] a);
    inc_sat = (a == 16'hffff) ? a : a + 16'h1;
  endfunction

  function automatic logic is_chg(input lcs_state_t s);
    is_chg = (s == ST_SOFT) || (s == ST_PRE) || (s == ST_ABS) ||
             (s == ST_CCCV) || (s == ST_BSR_A) || (s == ST_BSR_D);
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    logic sus;
    logic lim;
    logic low_i;
    logic [4:0] goal;
    logic [5:0] vsum;
    logic [16:0] trial;
    sus = 1'b0;
    lim = 1'b0;
    low_i = 1'b0;
    goal = 5'h0;
    vsum = 6'h0;
    trial = 17'h0;
    n = q;
    n.pready = 1'b0;
    n.pslverr = 1'b0;

    // apb slave, one wait state
    if (psel && penable && !q.pready) begin
      n.pready = 1'b1;
      n.prdata = 32'h0;
      if (pwrite) begin
        case (paddr)
          `LCS_A_CTRL: begin
            n.susp = pwdata[`LCS_C_SUSP];
            if (pwdata[`LCS_C_RUNBSR]) begin
              n.pend = 1'b1;
            end
            n.lfp = pwdata[`LCS_C_LFP];
            n.irq_en = pwdata[`LCS_C_IRQEN];
            n.cx_en = pwdata[`LCS_C_CXEN];
          end
          // 5-bit field caps the servo at 32mV
          `LCS_A_ICHG: n.ichg = pwdata[4:0];
          `LCS_A_VCHG: n.vchg = pwdata[4:0];
          `LCS_A_ABS: n.aoff = pwdata[4:0];
          `LCS_A_MAXCHG: n.max_chg = pwdata[15:0];
          `LCS_A_MAXCV: n.max_cv = pwdata[15:0];
          `LCS_A_MAXABS: n.max_abs = pwdata[15:0];
          `LCS_A_CX: n.cx_thr = pwdata[15:0];
          `LCS_A_STAT: begin
            if (pwdata[`LCS_S_FAULT]) begin
              n.fault = 1'b0;
            end
          end
          `LCS_A_BSR, `LCS_A_IBSR, `LCS_A_TMR: ;
          default: n.pslverr = 1'b1;
        endcase
      end else begin
        case (paddr)
          `LCS_A_CTRL: n.prdata = {27'h0, q.cx_en, q.irq_en, q.lfp,
                                   q.pend, q.susp};
          `LCS_A_ICHG: n.prdata = {27'h0, q.ichg};
          `LCS_A_VCHG: n.prdata = {27'h0, q.vchg};
          `LCS_A_ABS: n.prdata = {27'h0, q.aoff};
          `LCS_A_MAXCHG: n.prdata = {16'h0, q.max_chg};
          `LCS_A_MAXCV: n.prdata = {16'h0, q.max_cv};
          `LCS_A_MAXABS: n.prdata = {16'h0, q.max_abs};
          `LCS_A_CX: n.prdata = {16'h0, q.cx_thr};
          `LCS_A_STAT: n.prdata = {18'h0, q.st == ST_DONE,
                                   q.st == ST_TMO, q.fault, q.peak,
                                   q.uvcl, q.iin, cv_reached,
                                   q.st == ST_ABS, q.st == ST_CCCV,
                                   q.st == ST_PRE, q.st};
          `LCS_A_BSR: n.prdata = {16'h0, q.bsr};
          `LCS_A_IBSR: n.prdata = {16'h0, q.ibsr};
          `LCS_A_TMR: n.prdata = {16'h0, q.tmr};
          default: n.pslverr = 1'b1;
        endcase
      end
    end

    lim = iin_limit_hit || undervoltage_feedback_input;
    low_i = battery_current_reading < q.cx_thr;
    if (sec_tick) begin
      n.sec = inc_sat(q.sec);
    end
    // safety timer runs only in the charging states, resistance test included
    if (sec_tick && is_chg(q.st)) begin
      n.tmr = inc_sat(q.tmr);
    end

    sus = vin_near_batt || sys_fault || q.susp;
    if (sus) begin
      n.st = ST_SUSP;
      n.sec = 16'h0;
    end else begin
      case (q.st)
        ST_SUSP: begin
          n.st = ST_DET;
          n.sec = 16'h0;
        end
        ST_DET: begin
          if (thermistor_input) begin
            n.st = ST_FAULT;
          end else if (!batt_stable) begin
            n.st = ST_OPEN;
            n.sec = 16'h0;
            n.dac = 5'h0;
          end else if (q.sec >= `LCS_DET_SEC) begin
            n.st = ST_SOFT;
            n.dac = 5'h0;
            n.tmr = 16'h0;
          end
        end
        ST_OPEN: begin
          if (thermistor_input) begin
            n.st = ST_FAULT;
          end else if (q.sec >= `LCS_OPEN_SEC) begin
            n.st = batt_in_range ? ST_SOFT : ST_FAULT;
            n.dac = 5'h0;
            n.tmr = 16'h0;
          end
        end
        ST_FAULT: ;
        ST_SOFT: begin
          // a held input limit stalls the ramp, not the cycle
          if (step_tick && !lim && q.dac < q.ichg) begin
            n.dac = q.dac + 5'h1;
          end
          if (q.dac == q.ichg) begin
            n.sec = 16'h0;
            if (!q.lfp && filtered_battery_code < `LCS_PRE_ENTER &&
                battery_sense_input > `LCS_SNS_2V6) begin
              n.st = ST_PRE;
              n.dac = div10(q.ichg);
            end else if (q.lfp && q.aoff != 5'h0) begin
              n.st = ST_ABS;
            end else begin
              n.st = ST_CCCV;
            end
          end
        end
        ST_PRE: begin
          if (filtered_battery_code > `LCS_PRE_EXIT) begin
            n.st = ST_CCCV;
            n.sec = 16'h0;
          end
        end
        ST_ABS: begin
          if (q.sec >= q.max_abs || (cv_reached && low_i)) begin
            n.st = ST_CCCV;
            n.sec = 16'h0;
          end
        end
        ST_CCCV: begin
          if (!cv_reached) begin
            n.sec = 16'h0;
          end else if ((q.cx_en && low_i) ||
                       (q.sec >= q.max_cv &&
                        !(q.lfp && q.max_cv == 16'h0))) begin
            n.st = ST_DONE;
            n.tmr = 16'h0;
          end
        end
        ST_BSR_A: begin
          if (step_tick) begin
            n.hold = q.hold + 4'h1;
          end
          if (q.hold == `LCS_BSR_HOLD) begin
            n.dv = sub_sat(q.v1, filtered_battery_code);
            n.di = sub_sat(q.i1, battery_current_reading);
            n.rem = 17'h0;
            n.nbit = 5'h0;
            n.st = ST_BSR_D;
          end
        end
        ST_BSR_D: begin
          // restoring divide, one quotient bit per clock
          trial = {q.rem[15:0], q.dv[15]};
          n.dv = {q.dv[14:0], 1'b0};
          if (trial >= {1'b0, q.di}) begin
            n.rem = trial - {1'b0, q.di};
            n.dv[0] = 1'b1;
          end else begin
            n.rem = trial;
          end
          n.nbit = q.nbit + 5'h1;
          if (q.nbit == 5'h0f) begin
            n.bsr = (q.di == 16'h0) ? 16'hffff : n.dv;
            n.ibsr = q.di;
            n.pend = 1'b0;
            n.st = q.ret;
          end
        end
        ST_DONE: ;
        ST_TMO: begin
          if (batt_below_35pct) begin
            n.st = ST_DET;
            n.sec = 16'h0;
            n.tmr = 16'h0;
          end
        end
        default: n.st = ST_SUSP;
      endcase

      // pending request only runs once charging is past soft-start
      if ((q.st == ST_PRE || q.st == ST_ABS || q.st == ST_CCCV) &&
          n.st == q.st && q.pend) begin
        n.st = ST_BSR_A;
        n.ret = q.st;
        n.v1 = filtered_battery_code;
        n.i1 = battery_current_reading;
        n.hold = 4'h0;
      end
      if (is_chg(q.st) && q.tmr > q.max_chg) begin
        n.st = ST_TMO;
      end
    end

    // current servo in the main charging phases
    goal = (q.st == ST_PRE) ? div10(q.ichg) : q.ichg;
    if (step_tick && (q.st == ST_PRE || q.st == ST_ABS ||
                      q.st == ST_CCCV)) begin
      if (lim && q.dac != 5'h0) begin
        n.dac = q.dac - 5'h1;
      end else if (!lim && q.dac < goal) begin
        n.dac = q.dac + 5'h1;
      end else if (q.dac > goal) begin
        n.dac = q.dac - 5'h1;
      end
    end
    n.iin = iin_limit_hit && is_chg(q.st);
    n.uvcl = undervoltage_feedback_input && is_chg(q.st);

    if (battery_sense_input < `LCS_SNS_2V4) begin
      n.peak = 1'b1;
    end else if (battery_sense_input > `LCS_SNS_2V6) begin
      n.peak = 1'b0;
    end

    vsum = {1'b0, q.vchg} + {1'b0, q.aoff};
    if (n.st == ST_ABS) begin
      n.vreg = (vsum > {1'b0, `LCS_VREG_MAX}) ? `LCS_VREG_MAX
                                              : vsum[4:0];
    end else begin
      n.vreg = q.vchg;
    end

    // set beats a same-cycle clear
    if (n.st == ST_FAULT) begin
      n.fault = 1'b1;
    end
    n.irq = n.fault && n.irq_en;
    n.chg_en = (is_chg(n.st) && n.st != ST_BSR_A) || n.st == ST_OPEN;
    n.load_en = n.st == ST_DET;
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.st <= ST_SUSP;
      q.ret <= ST_CCCV;
      q.ichg <= `LCS_R_ICHG;
      q.vchg <= `LCS_R_VCHG;
      q.max_chg <= `LCS_R_MAXCHG;
      q.max_cv <= `LCS_R_MAXCV;
      q.max_abs <= `LCS_R_MAXABS;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign charger_en = q.chg_en;
  assign detect_load_en = q.load_en;
  assign icharge_dac = q.dac;
  assign vreg_code = q.vreg;
  assign peak_mode = q.peak;
  assign detect_irq = q.irq;
endmodule // lcs_sequencer

/* rtl/lcs_tick.sv */
`timescale 1ns/1ps
module lcs_tick #(
  parameter int unsigned DIV = 10000
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic en,
  output logic tick
);
  logic [31:0] cnt_q;
  logic tick_q;

  assign tick = tick_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (en) begin
        if (cnt_q >= DIV - 1) begin
          cnt_q <= 32'h0;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 32'h1;
        end
      end
    end
  end
endmodule // lcs_tick

/* test/lcs_batt_model.sv */
`timescale 1ns/1ps
// ==========================================
// battery pack seen by the sequencer
module lcs_batt_model (
  input wire logic charger_en,
  input wire logic [4:0] icharge_dac,
  output logic [15:0] filtered_battery_code,
  output logic [15:0] battery_sense_input,
  output logic [15:0] battery_current_reading,
  output logic vin_near_batt,
  output logic thermistor_input,
  output logic batt_stable,
  output logic batt_in_range,
  output logic batt_below_35pct,
  output logic cv_reached
);
  initial begin
    filtered_battery_code = 16'h3e80;
    battery_sense_input = 16'h0e10;
    vin_near_batt = 1'b0;
    thermistor_input = 1'b0;
    batt_stable = 1'b1;
    batt_in_range = 1'b1;
    batt_below_35pct = 1'b0;
    cv_reached = 1'b0;
  end
  // no current while off, so a suspend shows a real step
  assign battery_current_reading = charger_en ?
    {3'h0, icharge_dac, 8'h00} : 16'h0000;
endmodule // lcs_batt_model

/* test/lcs_checker.sv */
`timescale 1ns/1ps
`include "lcs_map.svh"
// ==========================================
// port checks for the charge sequencer
module lcs_checker (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] battery_sense_input,
  input wire logic vin_near_batt,
  input wire logic sys_fault,
  input wire logic charger_en,
  input wire logic detect_load_en,
  input wire logic [4:0] icharge_dac,
  input wire logic peak_mode,
  input wire logic detect_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  chk_fault_stop: assert property (
    sys_fault |=> !charger_en && !detect_load_en)
    else $error("charger active after a system fault");
  chk_vin_stop: assert property (
    vin_near_batt |=> !charger_en)
    else $error("charger active with input near battery");
  chk_ramp_step: assert property (
    {1'b0, icharge_dac} == {1'b0, $past(icharge_dac)} + 6'h01 |->
      $past(icharge_dac) == $past(icharge_dac, 2))
    else $error("current code stepped on consecutive cycles");
  chk_load_alone: assert property (
    detect_load_en |-> !charger_en)
    else $error("presence load on while charging");
  chk_irq_idle: assert property (
    $rose(detect_irq) |-> !charger_en)
    else $error("detect interrupt raised while charging");
  chk_peak_entry: assert property (
    $rose(peak_mode) |-> $past(battery_sense_input) < `LCS_SNS_2V4)
    else $error("peak mode entered above low threshold");
  chk_peak_exit: assert property (
    peak_mode && battery_sense_input > `LCS_SNS_2V6 |=> !peak_mode)
    else $error("peak mode held above high threshold");
  chk_apb_wait: assert property (
    psel && penable && !pready |=> pready)
    else $error("bus answer late");
  chk_apb_err: assert property (
    psel && penable && !pready && paddr > `LCS_A_TMR |=> pslverr)
    else $error("unmapped access not flagged");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("bus answer held too long");
endmodule // lcs_checker

bind lcs_sequencer lcs_checker lcs_checker_inst (.ref_clk, .arst_n, .psel,
  .penable, .paddr, .pready, .pslverr, .battery_sense_input, .vin_near_batt,
  .sys_fault, .charger_en, .detect_load_en, .icharge_dac, .peak_mode,
  .detect_irq);

/* test/tb_lcs_sequencer.sv */
`timescale 1ns/1ps
`include "lcs_map.svh"
module tb_lcs_sequencer;
  import lcs_pkg::*;
  logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, perr;
  logic sys_fault, iin_limit_hit, undervoltage_feedback_input;
  logic charger_en, detect_load_en, peak_mode, detect_irq;
  logic vin_near_batt, thermistor_input, batt_stable, batt_in_range;
  logic batt_below_35pct, cv_reached;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [4:0] icharge_dac, vreg_code;
  logic [15:0] filtered_battery_code, battery_sense_input;
  logic [15:0] battery_current_reading;
  int bad_count, comparisons, n;

  lcs_sequencer #(.STEP_CYC(4), .SEC_STEPS(4)) lcs_sequencer_inst (
    .ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .filtered_battery_code, .battery_sense_input,
    .battery_current_reading, .vin_near_batt, .sys_fault, .thermistor_input,
    .batt_stable, .batt_in_range, .batt_below_35pct, .cv_reached,
    .iin_limit_hit, .undervoltage_feedback_input, .charger_en,
    .detect_load_en, .icharge_dac, .vreg_code, .peak_mode, .detect_irq);
  lcs_batt_model lcs_batt_model_inst (.charger_en, .icharge_dac,
    .filtered_battery_code, .battery_sense_input, .battery_current_reading,
    .vin_near_batt, .thermistor_input, .batt_stable, .batt_in_range,
    .batt_below_35pct, .cv_reached);

  // ==========================================
  // shared tasks
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input logic ok);
    if (ok !== 1'b1) begin
      bad_count++;
      $display("Error at %0t: wait ran out, got %h expected %h", $time, ok,
               1'b1);
      results();
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    wt(pready);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // suspend then release, so the charge, fault, precharge and timeout scenarios open a fresh cycle
  task automatic start(input logic [31:0] c);
    apb(1'b1, `LCS_A_CTRL, c | 32'h1);
    apb(1'b1, `LCS_A_CTRL, c);
  endtask
  task automatic batt(input logic [15:0] c, input logic [15:0] s);
    lcs_batt_model_inst.filtered_battery_code <= c;
    lcs_batt_model_inst.battery_sense_input <= s;
  endtask

  // ==========================================
  // scenarios
  task automatic t_regs();
    logic [7:0] a [6] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    logic [31:0] e [6] = '{32'h1f, 32'h1f, 32'h0, 32'hfd20, 32'he10,
                           32'h384};
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, a[i], 32'h0);
      chk(rdat, e[i]);
    end
    apb(1'b1, 8'h40, 32'h5);
    chk(perr, 1'b1);
    $display("test regs done");
  endtask
  task automatic t_charge();
    int c;
    apb(1'b1, `LCS_A_ICHG, 32'h5);
    start(32'h0);
    for (n = 0; n < 300 && detect_load_en !== 1'b1; n++) cyc(1);
    wt(detect_load_en);
    chk(charger_en, 1'b0);
    for (n = 0; n < 300 && charger_en !== 1'b1; n++) cyc(1);
    wt(charger_en);
    for (c = 0; c < 100 && icharge_dac !== 5'h5; c++) cyc(1);
    chk(c >= 12 && c <= 28, 1'b1);
    cyc(12);
    chk(icharge_dac, 5'h5);
    apb(1'b0, `LCS_A_STAT, 32'h0);
    chk(rdat[5], 1'b1);
    lcs_batt_model_inst.vin_near_batt <= 1'b1;
    cyc(2);
    chk(charger_en, 1'b0);
    lcs_batt_model_inst.vin_near_batt <= 1'b0;
    for (n = 0; n < 300 && charger_en !== 1'b1; n++) cyc(1);
    wt(charger_en);
    sys_fault <= 1'b1;
    cyc(2);
    chk(charger_en, 1'b0);
    chk(detect_load_en, 1'b0);
    sys_fault <= 1'b0;
    $display("test charge done");
  endtask
  task automatic t_fault();
    lcs_batt_model_inst.batt_stable <= 1'b0;
    lcs_batt_model_inst.batt_in_range <= 1'b0;
    start(32'h8);
    for (n = 0; n < 400 && detect_irq !== 1'b1; n++) cyc(1);
    wt(detect_irq);
    chk(charger_en, 1'b0);
    apb(1'b0, `LCS_A_STAT, 32'h0);
    chk(rdat[11], 1'b1);
    lcs_batt_model_inst.batt_stable <= 1'b1;
    lcs_batt_model_inst.batt_in_range <= 1'b1;
    $display("test fault done");
  endtask
  task automatic t_pre();
    apb(1'b1, `LCS_A_ICHG, 32'h14);
    batt(16'h36b0, 16'h0bb8);
    start(32'h0);
    for (n = 0; n < 300 && charger_en !== 1'b1; n++) cyc(1);
    wt(charger_en);
    // soft-start passes code 2 on its way up, so wait for the top first
    for (n = 0; n < 300 && icharge_dac !== 5'h14; n++) cyc(1);
    wt(icharge_dac === 5'h14);
    cyc(8);
    chk(icharge_dac, 5'h2);
    apb(1'b0, `LCS_A_STAT, 32'h0);
    chk(rdat[4], 1'b1);
    batt(16'h3e80, 16'h0e10);
    for (n = 0; n < 300 && icharge_dac !== 5'h14; n++) cyc(1);
    wt(icharge_dac === 5'h14);
    apb(1'b0, `LCS_A_STAT, 32'h0);
    chk(rdat[5:4], 2'b10);
    $display("test precharge done");
  endtask
  task automatic t_peak();
    batt(16'h3e80, 16'h07d0);
    for (n = 0; n < 20 && peak_mode !== 1'b1; n++) cyc(1);
    wt(peak_mode);
    batt(16'h3e80, 16'h09c4);
    cyc(8);
    chk(peak_mode, 1'b1);
    batt(16'h3e80, 16'h0b54);
    for (n = 0; n < 20 && peak_mode !== 1'b0; n++) cyc(1);
    chk(peak_mode, 1'b0);
    iin_limit_hit <= 1'b1;
    undervoltage_feedback_input <= 1'b1;
    cyc(12);
    chk(icharge_dac < 5'h14, 1'b1);
    apb(1'b0, `LCS_A_STAT, 32'h0);
    chk(rdat[9:8], 2'b11);
    iin_limit_hit <= 1'b0;
    undervoltage_feedback_input <= 1'b0;
    $display("test peak done");
  endtask
  task automatic t_bsr();
    apb(1'b1, `LCS_A_CTRL, 32'h2);
    for (n = 0; n < 20 && charger_en !== 1'b0; n++) cyc(1);
    wt(!charger_en);
    for (n = 0; n < 200 && charger_en !== 1'b1; n++) cyc(1);
    wt(charger_en);
    cyc(24);
    apb(1'b0, `LCS_A_CTRL, 32'h0);
    chk(rdat[1], 1'b0);
    apb(1'b0, `LCS_A_IBSR, 32'h0);
    chk(rdat[15:0] !== 16'h0, 1'b1);
    $display("test resistance done");
  endtask
  task automatic t_tmo();
    apb(1'b1, `LCS_A_MAXCHG, 32'h2);
    start(32'h0);
    for (n = 0; n < 300 && charger_en !== 1'b1; n++) cyc(1);
    wt(charger_en);
    for (n = 0; n < 200 && charger_en !== 1'b0; n++) cyc(1);
    wt(!charger_en);
    apb(1'b0, `LCS_A_STAT, 32'h0);
    chk(rdat[12], 1'b1);
    cyc(40);
    chk(detect_load_en, 1'b0);
    lcs_batt_model_inst.batt_below_35pct <= 1'b1;
    for (n = 0; n < 20 && detect_load_en !== 1'b1; n++) cyc(1);
    wt(detect_load_en);
    $display("test timeout done");
  endtask

  // ==========================================
  // clock, reset and sequence
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sys_fault = 1'b0;
    iin_limit_hit = 1'b0;
    undervoltage_feedback_input = 1'b0;
    cyc(10);
    arst_n <= 1'b1;
    cyc(1);
    apb(1'b1, `LCS_A_CTRL, 32'h1);
    t_regs();
    t_charge();
    t_fault();
    t_pre();
    t_peak();
    t_bsr();
    t_tmo();
    results();
  end
endmodule // tb_lcs_sequencer
